// ==== design/twrs_host.sv ====
// two-wire bus master that reads and writes 16-bit registers of the slave
// Functional notes
// - slave only; master drives clock, shares data
// - address lsb 0 writes, 1 reads
// - first write byte is the register pointer
// - master ends write with start or stop
// - read: pointer write, repeated start, read address
// - master acknowledges read bytes; pointer advances
// - master ends read with no-acknowledge
// - idle both high; only master makes start/stop
// - one bit per pulse, data steady high
// - sender releases line; receiver pulls low ack
// - no-acknowledge is line left high
`timescale 1ns/1ps
`default_nettype none

module twrs_host #(
    parameter int QTR_CYCLES = twrs_pkg::QTR_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // strap level chosen for the slave
    input wire logic ADDR_SEL,
    output var logic BUS_ADDRESS_SELECT_PIN,
    // request
    input wire logic CMD_VALID,
    input wire twrs_pkg::twrs_cmd_t CMD,
    output var logic CMD_READY,
    // answer
    output var logic RSP_VALID,
    output var twrs_pkg::twrs_rsp_t RSP,
    // serial clock, driven by this master only
    output var logic SCL_O,
    // open-drain serial data line
    input wire logic SERIAL_DATA_LINE_I,
    output var logic SERIAL_DATA_LINE_O,
    output var logic SERIAL_DATA_LINE_OE_N
);
    import twrs_pkg::*;

    twrs_state_t st_reg;
    twrs_cmd_t cmd_reg;
    logic [15:0] qcnt_reg;
    logic [1:0] ph_reg;
    logic [3:0] bitn_reg;
    logic [2:0] step_reg;
    logic [7:0] tx_sh_reg;
    logic [15:0] rx_sh_reg;
    logic nack_reg;
    logic sel_reg;
    logic sda_meta_reg;
    logic sda_sync_reg;
    logic scl_reg;
    logic sda_oe_n_reg;
    logic ready_reg;
    logic rsp_valid_reg;
    logic scl_next;
    logic drive_low_next;
    logic bit_end;
    logic accept;
    logic [7:0] addr_wr;

    ////////////////////////////////////////////////////////////////////////
    // strap and pin synchroniser

    // strap output follows the user's choice
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sel_reg <= 1'b0;
        end else begin
            sel_reg <= ADDR_SEL;
        end
    end

    // data line comes from outside, two flops before use
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
        end else begin
            sda_meta_reg <= SERIAL_DATA_LINE_I;
            sda_sync_reg <= sda_meta_reg;
        end
    end

    // address byte picked by the strap level
    assign addr_wr = sel_reg ? SLV_ADDR_STRAP_HIGH : SLV_ADDR_STRAP_LOW;

    // byte sent at each step of a command
    function automatic logic [7:0] tx_byte(input twrs_cmd_t c, input logic [2:0] s,
                                           input logic [7:0] aw);
        logic [7:0] b;
        b = aw; // write-mode address, lsb clear
        unique case (s)
            STEP_ADDR_WR: b = aw;
            STEP_POINTER: b = c.lower_half ? LOWER_BYTE_ACCESS_REG : c.ptr;
            STEP_THIRD: b = c.rd ? (aw | DIR_READ_BIT) : c.data[15:8];
            STEP_FOURTH: b = c.data[7:0];
            default: b = aw;
        endcase
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bit timing: four quarter phases per serial clock period

    assign bit_end = (qcnt_reg == 16'(QTR_CYCLES - 1)) && (ph_reg == 2'd3);
    assign accept = (st_reg == ST_IDLE) && CMD_VALID && ready_reg;

    // quarter counter runs only while a command is on the bus
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            qcnt_reg <= 16'h0000;
            ph_reg <= 2'd0;
        end else if (st_reg == ST_IDLE) begin
            qcnt_reg <= 16'h0000;
            ph_reg <= 2'd0;
        end else if (qcnt_reg == 16'(QTR_CYCLES - 1)) begin
            qcnt_reg <= 16'h0000;
            ph_reg <= ph_reg + 2'd1;
        end else begin
            qcnt_reg <= qcnt_reg + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    // one bit per pulse, nine pulses per byte with the acknowledge slot
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_reg <= ST_IDLE;
            cmd_reg <= '0;
            step_reg <= STEP_ADDR_WR;
            bitn_reg <= 4'h0;
            tx_sh_reg <= 8'h00;
            rx_sh_reg <= 16'h0000;
            nack_reg <= 1'b0;
        end else if (accept) begin
            st_reg <= ST_START;
            cmd_reg <= CMD;
            step_reg <= STEP_ADDR_WR;
            bitn_reg <= 4'h0;
            rx_sh_reg <= 16'h0000;
            nack_reg <= 1'b0;
        end else if (bit_end) begin
            unique case (st_reg)
                ST_START: begin
                    st_reg <= ST_TX;
                    bitn_reg <= 4'h0;
                    tx_sh_reg <= tx_byte(cmd_reg, step_reg, addr_wr);
                end
                ST_TX: begin
                    if (bitn_reg != ACK_SLOT) begin
                        // msb first on the wire
                        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                        bitn_reg <= bitn_reg + 4'h1;
                    end else if (sda_sync_reg) begin
                        // line left high is a refusal, never an ack
                        nack_reg <= 1'b1;
                        st_reg <= ST_STOP;
                    end else if (!cmd_reg.rd) begin
                        // data bytes (only the upper one in byte mode) go in one burst; stop closes it
                        if (step_reg == (cmd_reg.byte_mode ? STEP_THIRD : STEP_FOURTH)) begin
                            st_reg <= ST_STOP;
                        end else begin
                            step_reg <= step_reg + 3'h1;
                            bitn_reg <= 4'h0;
                            tx_sh_reg <= tx_byte(cmd_reg, step_reg + 3'h1, addr_wr);
                        end
                    end else if (step_reg == STEP_ADDR_WR) begin
                        step_reg <= STEP_POINTER;
                        bitn_reg <= 4'h0;
                        tx_sh_reg <= tx_byte(cmd_reg, STEP_POINTER, addr_wr);
                    end else if (step_reg == STEP_POINTER) begin
                        // repeated start, then the read-mode address
                        step_reg <= STEP_THIRD;
                        st_reg <= ST_START;
                    end else begin
                        step_reg <= STEP_FOURTH;
                        st_reg <= ST_RX;
                        bitn_reg <= 4'h0;
                    end
                end
                ST_RX: begin
                    if (bitn_reg != ACK_SLOT) begin
                        rx_sh_reg <= {rx_sh_reg[14:0], sda_sync_reg};
                        bitn_reg <= bitn_reg + 4'h1;
                    end else if (step_reg == STEP_FOURTH && !cmd_reg.byte_mode) begin
                        step_reg <= STEP_RX_LOW;
                        bitn_reg <= 4'h0;
                    end else begin
                        st_reg <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    st_reg <= ST_IDLE;
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin levels

    // clock high in the late half of each bit; start and stop are special
    always_comb begin
        scl_next = 1'b1;
        drive_low_next = 1'b0;
        unique case (st_reg)
            ST_IDLE: begin
                scl_next = 1'b1;
                drive_low_next = 1'b0;
            end
            ST_START: begin
                // works for first and repeated start: release low, then fall
                scl_next = (ph_reg != 2'd0);
                drive_low_next = (ph_reg >= 2'd2);
            end
            ST_TX: begin
                scl_next = (ph_reg >= 2'd2);
                // release for the slave's acknowledge
                drive_low_next = (bitn_reg != ACK_SLOT) && !tx_sh_reg[7];
            end
            ST_RX: begin
                scl_next = (ph_reg >= 2'd2);
                // ack the upper byte, leave the last byte high
                drive_low_next = (bitn_reg == ACK_SLOT) && (step_reg == STEP_FOURTH)
                                 && !cmd_reg.byte_mode;
            end
            ST_STOP: begin
                scl_next = (ph_reg != 2'd0);
                drive_low_next = (ph_reg < 2'd2);
            end
            default: begin
                scl_next = 1'b1;
                drive_low_next = 1'b0;
            end
        endcase
    end

    // outputs registered so pins never glitch on state decode
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            scl_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
        end else begin
            scl_reg <= scl_next;
            sda_oe_n_reg <= !drive_low_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // handshake with the user side

    // ready drops on accept and returns with the answer
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ready_reg <= 1'b1;
            rsp_valid_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= (st_reg == ST_STOP) && bit_end;
            if (accept) begin
                ready_reg <= 1'b0;
            end else if ((st_reg == ST_STOP) && bit_end) begin
                ready_reg <= 1'b1;
            end
        end
    end

    assign CMD_READY = ready_reg;
    assign RSP_VALID = rsp_valid_reg;
    // one driver for the whole answer word
    assign RSP = '{nack: nack_reg, data: rx_sh_reg};
    assign SCL_O = scl_reg;
    assign SERIAL_DATA_LINE_O = 1'b0; // open drain: only ever pulls low
    assign SERIAL_DATA_LINE_OE_N = sda_oe_n_reg;
    assign BUS_ADDRESS_SELECT_PIN = sel_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // data moves under a high clock only for start and stop
    a_data_steady_high: assert property (
        (scl_reg && $past(scl_reg) && $changed(sda_oe_n_reg))
        |-> ($past(st_reg) == ST_START || $past(st_reg) == ST_STOP))
        else $error("data changed while clock high outside start or stop");

    // idle bus has both lines released
    a_idle_released: assert property (
        ($past(st_reg) == ST_IDLE) |-> (scl_reg && sda_oe_n_reg))
        else $error("bus not released while idle");

    // master releases the line in the slave's acknowledge slot
    a_tx_ack_release: assert property (
        ($past(st_reg) == ST_TX && $past(bitn_reg) == ACK_SLOT) |-> sda_oe_n_reg)
        else $error("master drove data during slave acknowledge");

    // master never drives while the slave sends read bits
    a_rx_bits_release: assert property (
        ($past(st_reg) == ST_RX && $past(bitn_reg) != ACK_SLOT) |-> sda_oe_n_reg)
        else $error("master drove data while slave sends");

    // upper read byte is acknowledged, the last one is not
    a_rx_ack_upper: assert property (
        ($past(st_reg) == ST_RX && $past(bitn_reg) == ACK_SLOT
         && $past(step_reg) == STEP_FOURTH && !$past(cmd_reg.byte_mode))
        |-> !sda_oe_n_reg)
        else $error("upper read byte not acknowledged");

    a_rx_nack_last: assert property (
        ($past(st_reg) == ST_RX && $past(bitn_reg) == ACK_SLOT
         && ($past(step_reg) == STEP_RX_LOW || $past(cmd_reg.byte_mode)))
        |-> sda_oe_n_reg)
        else $error("last read byte was acknowledged");

    // direction bit: write address low, read address high
    a_dir_bit_write: assert property (
        ($past(st_reg) == ST_TX && $past(step_reg) == STEP_ADDR_WR
         && $past(bitn_reg) == 4'h7) |-> !sda_oe_n_reg)
        else $error("write address sent with read direction");

    a_dir_bit_read: assert property (
        ($past(st_reg) == ST_TX && $past(step_reg) == STEP_THIRD && $past(cmd_reg.rd)
         && $past(bitn_reg) == 4'h7) |-> sda_oe_n_reg)
        else $error("read address sent with write direction");

    // every answer follows a stop, and ready returns with it
    a_answer_after_stop: assert property (
        $rose(rsp_valid_reg) |-> ($past(st_reg) == ST_STOP && ready_reg) ##1 !rsp_valid_reg)
        else $error("answer not closed by a stop");

    c_write_done: cover property (rsp_valid_reg && !cmd_reg.rd && !nack_reg);
    c_read_done: cover property (rsp_valid_reg && cmd_reg.rd && !nack_reg);
    c_refused: cover property (rsp_valid_reg && nack_reg);
    c_byte_read: cover property (rsp_valid_reg && cmd_reg.rd && cmd_reg.byte_mode);

endmodule

`default_nettype wire

// ==== design/twrs_pkg.sv ====
// constants and carrier types for the two-wire register bus master
package twrs_pkg;

    // slave byte addresses selected by the strap pin (write mode, lsb = 0)
    localparam logic [7:0] SLV_ADDR_STRAP_LOW = 8'h90;
    localparam logic [7:0] SLV_ADDR_STRAP_HIGH = 8'hba;
    localparam logic [7:0] DIR_READ_BIT = 8'h01;
    // pointer that carries the lower byte of the last addressed register
    localparam logic [7:0] LOWER_BYTE_ACCESS_REG = 8'hf1;

    // sequence steps of one command
    localparam logic [2:0] STEP_ADDR_WR = 3'h0;
    localparam logic [2:0] STEP_POINTER = 3'h1;
    localparam logic [2:0] STEP_THIRD = 3'h2;
    localparam logic [2:0] STEP_FOURTH = 3'h3;
    localparam logic [2:0] STEP_RX_LOW = 3'h4;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // serial clock timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int QTR_NS = SCL_PERIOD_NS / 4;
    // least time, so round up to whole cycles
    localparam int QTR_CYC = (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // one request from the user side
    typedef struct packed {
        logic rd;          // 1 = read, 0 = write
        logic byte_mode;   // move one register byte only: the upper one, or the lower one with lower_half
        logic lower_half;  // aim the pointer at the lower-byte register
        logic [7:0] ptr;   // register pointer
        logic [15:0] data; // write value, upper byte first on the wire
    } twrs_cmd_t;

    // one answer to the user side
    typedef struct packed {
        logic nack;        // slave refused a byte
        logic [15:0] data; // read value
    } twrs_rsp_t;

    typedef enum {
        ST_IDLE,
        ST_START,
        ST_TX,
        ST_RX,
        ST_STOP
    } twrs_state_t;

endpackage

// ==== dv/twrs_slave_model.sv ====
// behavioural two-wire slave with 16-bit registers, far side of the host
`timescale 1ns/1ps
`default_nettype none

module twrs_slave_model #(
    parameter logic [7:0] BAD_PTR = 8'hee
) (
    // serial pins seen at the slave
    input wire logic scl,
    input wire logic sda,
    input wire logic strap,
    // 1 = slave pulls the data line low
    output logic pull
);
    import twrs_pkg::*;

    logic [15:0] mem [256];
    logic [7:0] sh, ptr, last, pend, txb;
    logic act, ack_ph, tx;
    int bitc, bytec, rk;

    ////////////////////////////////////////////////////////////////////////
    // reset image; the pattern is arbitrary and mirrored by the bench
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = {i[7:0], ~i[7:0]};
        {pull, act, ack_ph, tx} = 4'h0;
        {ptr, last, pend, sh, txb} = 40'h0;
        {bitc, bytec, rk} = {32'h0, 32'h0, 32'h0};
    end

    // next byte to send: upper half first, then lower half; the special pointer sends the lower half of the last register
    task load_tx();
        if (ptr == LOWER_BYTE_ACCESS_REG) txb = mem[last][7:0];
        else if (rk[0] == 1'b0) begin
            txb = mem[ptr][15:8];
            last = ptr;
        end else begin
            txb = mem[ptr][7:0];
            ptr = ptr + 8'h01;
        end
        rk++;
    endtask

    // a received byte is decoded and answered in the acknowledge slot
    task byte_in();
        if (bytec == 0) begin
            pull = (sh[7:1] == (strap ? SLV_ADDR_STRAP_HIGH[7:1] : SLV_ADDR_STRAP_LOW[7:1]));
            act = pull;
            tx = sh[0];
            rk = 0;
        end else if (bytec == 1) begin
            pull = (sh != BAD_PTR);
            act = pull;
            ptr = sh;
        end else if (ptr == LOWER_BYTE_ACCESS_REG) begin
            mem[last] = {pend, sh};
            pull = 1'b1;
        end else if (bytec[0] == 1'b0) begin
            pend = sh;
            last = ptr;
            pull = 1'b1;
        end else begin
            mem[ptr] = {pend, sh};
            ptr = ptr + 8'h01;
            pull = 1'b1;
        end
        bytec++;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // start: the delay skips data that moves in the step the clock falls
    always @(negedge sda) begin
        #1;
        if (scl) begin
            {act, tx, ack_ph, pull} = 4'h8;
            bitc = 0;
            bytec = 0;
        end
    end

    // stop ends any transfer and releases the line
    always @(posedge sda) begin
        #1;
        if (scl) {act, pull} = 2'h0;
    end

    // one bit sampled per rising clock, msb first
    always @(posedge scl) if (act) begin
        if (!ack_ph) begin
            sh = {sh[6:0], sda};
            bitc++;
        end else if (tx && sda) act = 1'b0;
    end

    // drive only on the falling clock so data is steady while it is high
    always @(negedge scl) if (act) begin
        if (bitc == 8) begin
            ack_ph = 1'b1;
            bitc = 0;
            if (tx) pull = 1'b0;
            else byte_in();
        end else begin
            if (ack_ph && tx) load_tx();
            ack_ph = 1'b0;
            pull = tx && !txb[7 - bitc];
        end
    end
endmodule
`default_nettype wire

// ==== dv/test_two_wire_register_slave.sv ====
// self-checking bench: register host against the behavioural slave
`timescale 1ns/1ps
`default_nettype none

module test_two_wire_register_slave;
    import twrs_pkg::*;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic addr_sel = 1'b0;
    logic cmd_valid = 1'b0;
    twrs_cmd_t cmd = '0;
    twrs_rsp_t rsp;
    logic cmd_ready, rsp_valid, scl_o, sda_o, sda_oe_n, strap, pull;
    int fails = 0;
    int total_checks = 0;
    logic [15:0] ref_mem [256];
    logic [7:0] ref_last = 8'h00;
    logic [7:0] ref_pend = 8'h00;
    // open-drain data line with pull-up
    wire logic sda = ((!sda_oe_n && !sda_o) || pull) ? 1'b0 : 1'b1;

    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    twrs_host #(.QTR_CYCLES(4)) twrs_host_i (
        .CLK(clk), .SYS_RST(sys_rst), .ADDR_SEL(addr_sel),
        .BUS_ADDRESS_SELECT_PIN(strap), .CMD_VALID(cmd_valid), .CMD(cmd),
        .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP(rsp), .SCL_O(scl_o),
        .SERIAL_DATA_LINE_I(sda), .SERIAL_DATA_LINE_O(sda_o),
        .SERIAL_DATA_LINE_OE_N(sda_oe_n)
    );

    twrs_slave_model twrs_slave_model_i (
        .scl(scl_o), .sda(sda), .strap(strap), .pull(pull)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one command, compared with the register mirror at its answer
    task automatic run(input logic rd, input logic bm, input logic lh,
                       input logic [7:0] p, input logic [15:0] d);
        logic [15:0] exp;
        logic exp_nack;
        int n;
        exp = 16'h0000;
        exp_nack = (p == 8'hee) && !lh;
        @(negedge clk);
        check({15'h0, scl_o & sda}, 16'h0001);
        check({15'h0, strap}, {15'h0, addr_sel});
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{rd, bm, lh, p, d};
        @(negedge clk);
        check({15'h0, cmd_ready}, 16'h0001);
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(negedge clk);
        check({15'h0, cmd_ready}, 16'h0000);
        for (n = 0; n < 4000 && rsp_valid !== 1'b1; n++) @(negedge clk);
        check({15'h0, rsp_valid}, 16'h0001);
        if (exp_nack) exp = 16'h0000;
        else if (!rd && bm && lh) ref_mem[ref_last] = {ref_pend, d[15:8]};
        else if (!rd) begin
            ref_pend = d[15:8];
            ref_last = p;
            if (!bm) ref_mem[p] = d;
        end else if (lh) exp = {8'h00, ref_mem[ref_last][7:0]};
        else begin
            exp = bm ? {8'h00, ref_mem[p][15:8]} : ref_mem[p];
            ref_last = p;
        end
        check({15'h0, rsp.nack}, {15'h0, exp_nack});
        if (rd && !exp_nack) check(rsp.data, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [7:0] p;
        logic [15:0] d;
        for (int i = 0; i < 256; i++) ref_mem[i] = {i[7:0], ~i[7:0]};
        void'($urandom(32'hddbf));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        // both strap levels: reset value, write, read back
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            addr_sel <= i[0];
            repeat (2) @(posedge clk);
            p = 8'($urandom_range(0, 223));
            d = 16'($urandom);
            run(1'b1, 1'b0, 1'b0, p, 16'h0000);
            run(1'b0, 1'b0, 1'b0, p, d);
            run(1'b1, 1'b0, 1'b0, p, 16'h0000);
        end
        // single bytes: upper alone leaves the register, lower completes it
        p = 8'($urandom_range(0, 223));
        d = 16'($urandom);
        run(1'b0, 1'b1, 1'b0, p, d);
        run(1'b1, 1'b0, 1'b0, p, 16'h0000);
        run(1'b0, 1'b1, 1'b1, 8'h00, {d[7:0], 8'h00});
        run(1'b1, 1'b0, 1'b0, p, 16'h0000);
        run(1'b1, 1'b1, 1'b0, p, 16'h0000);
        run(1'b1, 1'b1, 1'b1, 8'h00, 16'h0000);
        // refused pointer in write and read, then a clean read
        run(1'b0, 1'b0, 1'b0, 8'hee, d);
        run(1'b1, 1'b0, 1'b0, 8'hee, 16'h0000);
        run(1'b1, 1'b0, 1'b0, p, 16'h0000);
        finish_test();
    end

    // hang guard, well beyond the roughly thirty commands of the run
    initial begin
        repeat (80000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule
`default_nettype wire
